/* rtl/gsr_top.sv */
// Report, two-wire target and recalibration control of the sensor.
// Assumes meas_ppm comes from logic on clk; pins are asynchronous.
// What this block does
// - Serial link 38400 baud, 8N1
// - Frame sent every 3 s, unrequested
// - Five digits, space, ppm, CR, LF
// - Two-wire target only, address 0x31
// - Address LSB: one read, zero write
// - Config byte, ppm word, four zeros
// - Sample refreshed every 5 s
// - Reported value clamped to 400..5000
// - Valid result within 6 s
// - Automatic recalibration mode after power-on
// - Auto recal at 3 days, then monthly
// - Manual recal ends within 18 min
`timescale 1ns/1ps
`default_nettype none
module gsr_top #(
  parameter int TICK_CYCLES = gsr_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Measurement engine
  input  wire logic [12:0] meas_ppm,
  input  wire logic        cal_done,
  // Serial output
  output logic             txd,
  // Two-wire port
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Recalibration pins and status
  input  wire logic        auto_dim_recal,
  input  wire logic        manual_dim_recal_b,
  output logic             recal_auto_start,
  output logic             recal_man_start,
  output logic             recal_man_busy,
  output gsr_pkg::gsr_sample_t report
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [39:0] to_ascii(input logic [12:0] v);
    logic [12:0] r;
    logic [39:0] s;
    r = v;
    s = '0;
    for (int i = 0; i < 5; i++) begin
      if (i != 0 && r == 13'h0000) begin
        s[i*8 +: 8] = gsr_pkg::CH_SPACE;
      end else begin
        s[i*8 +: 8] = gsr_pkg::CH_ZERO + 8'(r % 13'h000A);
      end
      r = r / 13'h000A;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers and one-second tick
  // ----------------------------------------------------------------
  logic [1:0] s_scl, s_sda, s_auto, s_man;
  logic       scl_d, sda_d;
  // Pins are asynchronous, two stages before use
  always_ff @(posedge clk) begin
    s_scl  <= {s_scl[0], scl_i};
    s_sda  <= {s_sda[0], sda_i};
    s_auto <= {s_auto[0], auto_dim_recal};
    s_man  <= {s_man[0], manual_dim_recal_b};
    scl_d  <= s_scl[1];
    sda_d  <= s_sda[1];
  end

  logic [26:0] tick_cnt;
  logic        tick;
  assign tick = (tick_cnt == 27'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!rst_b || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 27'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  logic [2:0]  samp_cnt;
  logic [12:0] clamped;
  logic [39:0] digits;
  assign clamped = (meas_ppm < gsr_pkg::PPM_MIN) ? gsr_pkg::PPM_MIN :
                   (meas_ppm > gsr_pkg::PPM_MAX) ? gsr_pkg::PPM_MAX : meas_ppm;
  // First sample one second after reset, then every five
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      samp_cnt <= 3'(gsr_pkg::SAMPLE_S - gsr_pkg::FIRST_SAMPLE_S);
      report   <= '{valid: 1'b0, ppm: gsr_pkg::PPM_MIN};
      digits   <= {5{gsr_pkg::CH_SPACE}};
    end else if (tick) begin
      if (samp_cnt == 3'(gsr_pkg::SAMPLE_S - 1)) begin
        samp_cnt <= '0;
        report   <= '{valid: 1'b1, ppm: clamped};
        digits   <= to_ascii(clamped);
      end else begin
        samp_cnt <= samp_cnt + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial frame transmitter
  // ----------------------------------------------------------------
  logic [1:0]  frame_cnt;
  logic        frame_go, tx_busy;
  logic [3:0]  tx_idx, tx_bit;
  logic [11:0] baud_cnt;
  logic [9:0]  tx_shift;
  logic [39:0] frame_dig;
  logic [7:0]  next_char;
  assign frame_go = tick && (frame_cnt == 2'(gsr_pkg::FRAME_S - 1));
  always_ff @(posedge clk) begin
    if (!rst_b || frame_go) begin
      frame_cnt <= '0;
    end else if (tick) begin
      frame_cnt <= frame_cnt + 2'h1;
    end
  end

  // Character at the next index, leading digit first
  always_comb begin
    case (tx_idx)
      4'h4:    next_char = gsr_pkg::CH_SPACE;
      4'h5:    next_char = gsr_pkg::CH_P;
      4'h6:    next_char = gsr_pkg::CH_P;
      4'h7:    next_char = gsr_pkg::CH_M;
      4'h8:    next_char = gsr_pkg::CH_CR;
      4'h9:    next_char = gsr_pkg::CH_LF;
      default: next_char = frame_dig[(3 - tx_idx[1:0])*8 +: 8];
    endcase
  end

  // Digits frozen at frame start so a new sample cannot tear it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_busy  <= 1'b0;
      tx_idx   <= '0;
      tx_bit   <= '0;
      baud_cnt <= '0;
      tx_shift <= '1;
      frame_dig <= '0;
    end else if (frame_go && !tx_busy) begin
      tx_busy  <= 1'b1;
      tx_idx   <= '0;
      tx_bit   <= '0;
      baud_cnt <= '0;
      frame_dig <= digits;
      tx_shift <= {1'b1, digits[39:32], 1'b0};
    end else if (tx_busy) begin
      if (baud_cnt == 12'(gsr_pkg::BIT_CYCLES - 1)) begin
        baud_cnt <= '0;
        if (tx_bit == gsr_pkg::UART_BITS - 4'h1) begin
          tx_bit <= '0;
          // Index FRAME_LEN - 1 is the line feed, the last character
          if (tx_idx == gsr_pkg::FRAME_LEN - 4'h1) begin
            tx_busy <= 1'b0;
          end else begin
            tx_idx   <= tx_idx + 4'h1;
            tx_shift <= {1'b1, next_char, 1'b0};
          end
        end else begin
          tx_bit   <= tx_bit + 4'h1;
          tx_shift <= {1'b1, tx_shift[9:1]};
        end
      end else begin
        baud_cnt <= baud_cnt + 12'h1;
      end
    end
  end
  assign txd = tx_busy ? tx_shift[0] : 1'b1;

  // ----------------------------------------------------------------
  // Two-wire target
  // ----------------------------------------------------------------
  gsr_pkg::gsr_i2c_state_t ist;
  logic [3:0]  ibit;
  logic [7:0]  ishift, txb;
  logic [2:0]  ridx;
  logic        rw, nack, drv_low;
  logic [12:0] res_ppm;
  logic        scl_rise, scl_fall, i_start, i_stop;
  assign scl_rise = s_scl[1] && !scl_d;
  assign scl_fall = !s_scl[1] && scl_d;
  assign i_start  = s_scl[1] && scl_d && !s_sda[1] && sda_d;
  assign i_stop   = s_scl[1] && scl_d && s_sda[1] && !sda_d;

  // Result byte by index, ppm word high byte first
  function automatic logic [7:0] res_byte(input logic [2:0] i, input logic [12:0] p);
    case (i)
      3'h0:    return gsr_pkg::CFG_BYTE;
      3'h1:    return {3'b000, p[12:8]};
      3'h2:    return p[7:0];
      default: return gsr_pkg::RSV_BYTE;
    endcase
  endfunction
  // Next result byte as a net, so its top bit can be selected
  logic [7:0]  next_rb;
  assign next_rb = res_byte(ridx, res_ppm);

  // Open drain: only ever pulls low, never drives the clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ist     <= gsr_pkg::I_IDLE;
      ibit    <= '0;
      ishift  <= '0;
      txb     <= '0;
      ridx    <= '0;
      rw      <= 1'b0;
      nack    <= 1'b0;
      drv_low <= 1'b0;
      res_ppm <= gsr_pkg::PPM_MIN;
    end else if (i_start) begin
      ist     <= gsr_pkg::I_ADDR;
      ibit    <= '0;
      drv_low <= 1'b0;
    end else if (i_stop) begin
      ist     <= gsr_pkg::I_IDLE;
      drv_low <= 1'b0;
    end else if (scl_rise) begin
      if (ist == gsr_pkg::I_ADDR || ist == gsr_pkg::I_WR) begin
        ishift <= {ishift[6:0], s_sda[1]};
        ibit   <= ibit + 4'h1;
      end else if (ist == gsr_pkg::I_RD) begin
        ibit <= ibit + 4'h1;
      end else if (ist == gsr_pkg::I_RACK) begin
        nack <= s_sda[1];
      end
    end else if (scl_fall) begin
      case (ist)
        gsr_pkg::I_ADDR: if (ibit == 4'h8) begin
          if (ishift[7:1] == gsr_pkg::TGT_ADDR) begin
            ist     <= gsr_pkg::I_ACKA;
            rw      <= ishift[0];
            drv_low <= 1'b1;
          end else begin
            ist <= gsr_pkg::I_IDLE;
          end
        end
        gsr_pkg::I_ACKA, gsr_pkg::I_RACK: begin
          ibit <= '0;
          if (ist == gsr_pkg::I_ACKA && !rw) begin
            ist     <= gsr_pkg::I_WR;
            drv_low <= 1'b0;
          end else if (ist == gsr_pkg::I_RACK && nack) begin
            ist     <= gsr_pkg::I_IDLE;
            drv_low <= 1'b0;
          end else begin
            ist     <= gsr_pkg::I_RD;
            txb     <= next_rb;
            drv_low <= !next_rb[7];
            ridx    <= (ridx == gsr_pkg::RES_LEN) ? ridx : ridx + 3'h1;
          end
        end
        gsr_pkg::I_WR: if (ibit == 4'h8) begin
          ist     <= gsr_pkg::I_ACKW;
          drv_low <= 1'b1;
          if (ishift == gsr_pkg::CMD_READ) begin
            res_ppm <= report.ppm;
            ridx    <= '0;
          end
        end
        gsr_pkg::I_ACKW: begin
          ist     <= gsr_pkg::I_WR;
          ibit    <= '0;
          drv_low <= 1'b0;
        end
        gsr_pkg::I_RD: begin
          if (ibit == 4'h8) begin
            ist     <= gsr_pkg::I_RACK;
            drv_low <= 1'b0;
          end else begin
            drv_low <= !txb[3'(4'h7 - ibit)];
          end
        end
        default: drv_low <= 1'b0;
      endcase
    end
  end
  assign sda_o  = 1'b0;
  assign sda_oe = drv_low;

  // ----------------------------------------------------------------
  // Recalibration control
  // ----------------------------------------------------------------
  gsr_pkg::gsr_mode_t mode;
  logic [21:0] auto_cnt;
  logic [10:0] man_cnt;
  logic        auto_cond, man_cond;
  assign auto_cond = !s_auto[1] && s_man[1];
  assign man_cond  = s_auto[1] && !s_man[1];

  // Day counter runs from power-on in every mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      auto_cnt         <= 22'(gsr_pkg::AUTO_FIRST_S - 1);
      recal_auto_start <= 1'b0;
    end else begin
      recal_auto_start <= 1'b0;
      if (tick) begin
        if (auto_cnt == '0) begin
          auto_cnt         <= 22'(gsr_pkg::AUTO_PERIOD_S - 1);
          recal_auto_start <= auto_cond && mode == gsr_pkg::M_AUTO;
        end else begin
          auto_cnt <= auto_cnt - 22'h1;
        end
      end
    end
  end

  // Manual hold is timed, then calibration is bounded
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode            <= gsr_pkg::M_AUTO;
      man_cnt         <= '0;
      recal_man_start <= 1'b0;
    end else begin
      recal_man_start <= 1'b0;
      case (mode)
        gsr_pkg::M_AUTO: begin
          man_cnt <= '0;
          if (man_cond) begin
            mode <= gsr_pkg::M_HOLD;
          end
        end
        gsr_pkg::M_HOLD: begin
          if (!man_cond) begin
            mode <= gsr_pkg::M_AUTO;
          end else if (tick) begin
            if (man_cnt == 11'(gsr_pkg::MAN_HOLD_S - 1)) begin
              mode            <= gsr_pkg::M_CAL;
              man_cnt         <= '0;
              recal_man_start <= 1'b1;
            end else begin
              man_cnt <= man_cnt + 11'h1;
            end
          end
        end
        gsr_pkg::M_CAL: begin
          if (cal_done || (tick && man_cnt == 11'(gsr_pkg::MAN_LIMIT_S - 1))) begin
            mode <= gsr_pkg::M_AUTO;
          end else if (tick) begin
            man_cnt <= man_cnt + 11'h1;
          end
        end
        default: mode <= gsr_pkg::M_AUTO;
      endcase
    end
  end
  assign recal_man_busy = (mode == gsr_pkg::M_CAL);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bit_stable;
    @(posedge clk) disable iff (!rst_b)
      (tx_busy && baud_cnt != '0) |-> $stable(txd);
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("txd moved mid bit");

  property p_stop_high;
    @(posedge clk) disable iff (!rst_b)
      (tx_busy && tx_bit == 4'h9) |-> txd;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");

  property p_frame_on_tick;
    @(posedge clk) disable iff (!rst_b)
      $rose(tx_busy) |-> $past(frame_go);
  endproperty
  a_frame_on_tick: assert property (p_frame_on_tick) else $error("frame off schedule");

  property p_space_char;
    @(posedge clk) disable iff (!rst_b)
      (tx_busy && tx_idx == 4'h5 && tx_bit == '0 && baud_cnt == 12'h001)
        |-> tx_shift[8:1] == gsr_pkg::CH_SPACE;
  endproperty
  a_space_char: assert property (p_space_char) else $error("separator wrong");

  property p_target_only;
    @(posedge clk) disable iff (!rst_b)
      sda_oe |-> (ist inside {gsr_pkg::I_ACKA, gsr_pkg::I_ACKW, gsr_pkg::I_RD});
  endproperty
  a_target_only: assert property (p_target_only) else $error("sda driven idle");

  property p_addr_match;
    @(posedge clk) disable iff (!rst_b)
      ($past(ist) == gsr_pkg::I_ADDR && ist == gsr_pkg::I_ACKA)
        |-> $past(ishift[7:1]) == gsr_pkg::TGT_ADDR && rw == $past(ishift[0]);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("bad address acked");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
      (ist == gsr_pkg::I_RD && ridx > 3'h3) |-> txb == gsr_pkg::RSV_BYTE;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero");

  property p_span;
    @(posedge clk) disable iff (!rst_b)
      report.ppm >= gsr_pkg::PPM_MIN && report.ppm <= gsr_pkg::PPM_MAX;
  endproperty
  a_span: assert property (p_span) else $error("ppm out of span");

  property p_auto_cond;
    @(posedge clk) disable iff (!rst_b)
      recal_auto_start |-> $past(auto_cond) && $past(auto_cnt) == '0;
  endproperty
  a_auto_cond: assert property (p_auto_cond) else $error("auto recal wrongly");

  property p_reset_mode;
    @(posedge clk) !rst_b |=> mode == gsr_pkg::M_AUTO && !report.valid;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("reset state wrong");
endmodule
`default_nettype wire

/* pkg/gsr_pkg.sv */
// Shared constants and types of the gas sensor report interface.
// Assumes a single 100 MHz clock domain.
`default_nettype none
package gsr_pkg;
  // ----------------------------------------------------------------
  // Clock and serial timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 100_000_000;
  localparam int BAUD       = 38400;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam logic [3:0] UART_BITS = 4'hA;  // Start, eight data, stop
  localparam logic [3:0] FRAME_LEN = 4'hB;
  // ----------------------------------------------------------------
  // Times in seconds; counted on a one-second tick
  // ----------------------------------------------------------------
  localparam int FRAME_S        = 3;
  localparam int SAMPLE_S       = 5;
  localparam int FIRST_SAMPLE_S = 1;
  localparam int DETECT_S       = 6;
  localparam int SEC_PER_DAY    = 86400;
  localparam int AUTO_FIRST_DAYS = 3;
  localparam int AUTO_PERIOD_DAYS = 30;
  localparam int AUTO_FIRST_S  = AUTO_FIRST_DAYS * SEC_PER_DAY;
  localparam int AUTO_PERIOD_S = AUTO_PERIOD_DAYS * SEC_PER_DAY;
  localparam int MAN_HOLD_S    = 10 * 60;
  localparam int MAN_LIMIT_S   = 18 * 60;
  // ----------------------------------------------------------------
  // Values and codes
  // ----------------------------------------------------------------
  localparam logic [12:0] PPM_MIN   = 13'h0190;  // 400
  localparam logic [12:0] PPM_MAX   = 13'h1388;  // 5000
  localparam logic [6:0]  TGT_ADDR  = 7'h31;
  localparam logic [7:0]  CMD_READ  = 8'h52;
  localparam logic [7:0]  CFG_BYTE  = 8'h08;
  localparam logic [7:0]  RSV_BYTE  = 8'h00;
  localparam logic [7:0]  CH_SPACE  = 8'h20;
  localparam logic [7:0]  CH_ZERO   = 8'h30;
  localparam logic [7:0]  CH_P      = 8'h70;
  localparam logic [7:0]  CH_M      = 8'h6D;
  localparam logic [7:0]  CH_CR     = 8'h0D;
  localparam logic [7:0]  CH_LF     = 8'h0A;
  localparam logic [2:0]  RES_LEN   = 3'h7;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [12:0] ppm;
  } gsr_sample_t;
  typedef enum logic [6:0] {
    I_IDLE = 7'h01, I_ADDR = 7'h02, I_ACKA = 7'h04, I_WR = 7'h08,
    I_ACKW = 7'h10, I_RD = 7'h20, I_RACK = 7'h40
  } gsr_i2c_state_t;
  typedef enum logic [2:0] {
    M_AUTO = 3'h1, M_HOLD = 3'h2, M_CAL = 3'h4
  } gsr_mode_t;
endpackage
`default_nettype wire

/* test/gsr_host_model.sv */
// Host model: two-wire bus master and serial receiver facing the block.
// Assumes one clock; the bench forms the pulled-up SDA wire.
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model (
  // Clock
  input  wire logic clk,
  // Serial line from the device
  input  wire logic txd,
  // Two-wire bus
  output logic      scl,
  output logic      sda_hi,
  input  wire logic sda
);
  localparam int HALF = 25;  // Bus phase length in clocks; a bit takes three phases
  logic [7:0] rx_q[$];
  int         cyc = 0;
  int         first_start = -1;
  int         stop_err = 0;
  initial scl = 1'b1;
  initial sda_hi = 1'b1;
  always @(posedge clk) cyc <= cyc + 1;
  // ------------------------------------------------------------
  // Serial receiver
  // ------------------------------------------------------------
  // Mid-bit sampling, 8N1, LSB first; no handshake exists to answer
  initial begin : rx_proc
    logic [7:0] b;
    wait (cyc > 8);  // Skip the unknown level before reset
    forever begin
      @(negedge txd);
      if (first_start < 0) first_start = cyc;
      repeat (gsr_pkg::BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (gsr_pkg::BIT_CYCLES) @(posedge clk);
        if (i < 8) b[i] = txd;
      end
      if (txd !== 1'b1) stop_err++;
      rx_q.push_back(b);
    end
  end
  // ------------------------------------------------------------
  // Two-wire master
  // ------------------------------------------------------------
  task automatic hp();
    repeat (HALF) @(posedge clk);
  endtask
  // Start, also usable as repeated start with SCL low
  task automatic start();
    sda_hi <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_hi <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_hi <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_hi <= 1'b1;
    hp();
  endtask
  // Data held through the high phase, sampled at its end
  task automatic put_bit(input logic v, output logic s);
    sda_hi <= v;
    hp();
    scl <= 1'b1;
    hp();
    s = sda;
    scl <= 1'b0;
    hp();
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(mack, ack);
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Bench for the sensor report block: reset, sample, two-wire, clamp,
// manual recalibration and serial frame. Assumes gsr_host_model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TICK = 50;  // Short tick so the 600-tick hold fits the run
  localparam int RD_GAP = 100;  // Gap between byte reads, scaled down like the tick
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic [12:0]          meas_ppm = 13'h04E7;  // 1255
  logic                 cal_done = 1'b0;
  logic                 auto_dim_recal = 1'b0;
  logic                 manual_dim_recal_b = 1'b1;
  logic                 txd, sda_o, sda_oe, scl, sda_hi;
  logic                 recal_auto_start, recal_man_start, recal_man_busy;
  gsr_pkg::gsr_sample_t report;
  int                   fails = 0, checked = 0, cyc = 0, rel = 0, autos = 0;
  // Wired-AND with the pull-up
  wire logic            sda = sda_hi & ~(sda_oe & ~sda_o);
  always #5 clk = ~clk;
  gsr_top #(.TICK_CYCLES(TICK)) gsr_top_inst (
    .clk(clk), .rst_b(rst_b), .meas_ppm(meas_ppm), .cal_done(cal_done),
    .txd(txd), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .auto_dim_recal(auto_dim_recal), .manual_dim_recal_b(manual_dim_recal_b),
    .recal_auto_start(recal_auto_start), .recal_man_start(recal_man_start),
    .recal_man_busy(recal_man_busy), .report(report));
  gsr_host_model gsr_host_model_inst (
    .clk(clk), .txd(txd), .scl(scl), .sda_hi(sda_hi), .sda(sda));
  // Cycle count, automatic-start pulses and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (recal_auto_start === 1'b1) autos <= autos + 1;
    if (cyc == 95000) begin
      fails++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Outputs while reset is held, then release
  task automatic t_reset();
    repeat (4) @(posedge clk);
    #1;
    check("report", report, {1'b0, 13'h0190});
    check("man_busy", recal_man_busy, 1'b0);
    check("txd_idle", txd, 1'b1);
    check("sda_oe", sda_oe, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    rel = gsr_host_model_inst.cyc;
  endtask
  // First sample lands well inside the detection time
  task automatic t_sample();
    repeat (2 * TICK + 5) @(posedge clk);
    #1;
    check("valid", report.valid, 1'b1);
    check("ppm", report.ppm, 13'h04E7);
  endtask
  // Command, then stop and a fresh start for a read of seven bytes, then a foreign address
  task automatic t_i2c();
    logic [7:0] rx;
    logic [7:0] exp[7];
    logic       ack;
    exp = '{gsr_pkg::CFG_BYTE, 8'h04, 8'hE7, 8'h00, 8'h00, 8'h00, 8'h00};
    gsr_host_model_inst.start();
    gsr_host_model_inst.xfer(8'h62, 1'b1, rx, ack);
    check("ack_wr_addr", ack, 1'b0);
    gsr_host_model_inst.xfer(8'h52, 1'b1, rx, ack);
    check("ack_cmd", ack, 1'b0);
    gsr_host_model_inst.stop();
    gsr_host_model_inst.start();
    gsr_host_model_inst.xfer(8'h63, 1'b1, rx, ack);
    check("ack_rd_addr", ack, 1'b0);
    for (int i = 0; i < 7; i++) begin
      gsr_host_model_inst.xfer(8'hFF, i == 6, rx, ack);
      check("rd_byte", rx, exp[i]);
      repeat (RD_GAP) @(posedge clk);
    end
    gsr_host_model_inst.stop();
    gsr_host_model_inst.start();
    gsr_host_model_inst.xfer(8'h64, 1'b1, rx, ack);
    check("ack_foreign", ack, 1'b1);
    gsr_host_model_inst.stop();
  endtask
  // Samples outside the span are pinned to its ends
  task automatic t_clamp();
    meas_ppm <= 13'h1770;  // 6000
    repeat (5 * TICK + 5) @(posedge clk);
    #1;
    check("clamp_hi", report.ppm, 13'h1388);
    @(posedge clk);
    meas_ppm <= 13'h0064;  // 100
    repeat (5 * TICK + 5) @(posedge clk);
    #1;
    check("clamp_lo", report.ppm, 13'h0190);
  endtask
  // Interrupted hold is forgotten; a full hold starts, cal_done ends it
  task automatic t_manual();
    int n;
    @(posedge clk);
    auto_dim_recal <= 1'b1;
    manual_dim_recal_b <= 1'b0;
    repeat (300 * TICK) @(posedge clk);
    manual_dim_recal_b <= 1'b1;
    repeat (2 * TICK) @(posedge clk);
    manual_dim_recal_b <= 1'b0;
    n = 0;
    while (recal_man_start !== 1'b1 && n < 600 * TICK + 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("man_start", recal_man_start, 1'b1);
    check("hold_len", n >= 599 * TICK, 1'b1);
    @(posedge clk);
    #1;
    check("man_busy", recal_man_busy, 1'b1);
    @(posedge clk);
    cal_done <= 1'b1;
    manual_dim_recal_b <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    auto_dim_recal <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("busy_end", recal_man_busy, 1'b0);
    check("auto_pulses", 16'(autos), 16'h0000);
  endtask
  // Unrequested frame: timing, framing and right-justified digits
  task automatic t_frame();
    int n;
    int t;
    n = 0;
    while (gsr_host_model_inst.rx_q.size() < 3 && n < 90000) begin
      @(posedge clk);
      n++;
    end
    t = gsr_host_model_inst.first_start - rel;
    check("frame_time", t >= 3 * TICK - 3 && t <= 3 * TICK + 6, 1'b1);
    check("stop_bits", 16'(gsr_host_model_inst.stop_err), 16'h0000);
    check("char0", gsr_host_model_inst.rx_q[0], 8'h20);
    check("char1", gsr_host_model_inst.rx_q[1], 8'h31);
    check("char2", gsr_host_model_inst.rx_q[2], 8'h32);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    t_reset();
    t_sample();
    t_i2c();
    t_clamp();
    t_manual();
    t_frame();
    finish_test();
  end
endmodule
`default_nettype wire
